// [inc/spd_pkg.sv]
package spd_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] OFF_CFG    = 8'h00;
  localparam logic [7:0] OFF_SECURE = 8'h04;
  localparam logic [7:0] OFF_OTPLD  = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_VEL    = 8'h10;
  localparam logic [7:0] OFF_ACC    = 8'h14;
  localparam logic [7:0] OFF_GOTO   = 8'h18;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Motion parameter word, stored at OFF_CFG from bit 0 upward.
  typedef struct packed {
    logic       cont_vel;
    logic       sleep_permit;
    logic [1:0] microstep_select;
    logic       shaft;
    logic [3:0] acc;
    logic [3:0] vmin;
    logic [3:0] vmax;
    logic [3:0] ihold;
    logic [3:0] irun;
  } spd_cfg_s;

  localparam int CFG_W = 25;
  localparam spd_cfg_s CFG_RESET = 25'h0000000;

  // Current codes.
  localparam logic [3:0] CUR_ZERO_CODE = 4'hf;
  localparam logic [3:0] CUR_LOW_CODE  = 4'h0;

  // Secure target layout.
  localparam int SEC_W     = 11;
  localparam int SEC_OTP_W = 9;
  localparam int POS_W     = 16;
  localparam int SEC_PAD   = 5;
  localparam logic [8:0] SEC_DISABLE = 9'h100;
  localparam logic [10:0] SEC_RESET  = 11'h000;

  // Decoded microstep resolution, one-hot: 1/2, 1/4, 1/8, 1/16.
  localparam logic [3:0] STEP_HALF = 4'h1;
  localparam logic [3:0] STEP_QRT  = 4'h2;
  localparam logic [3:0] STEP_8TH  = 4'h4;
  localparam logic [3:0] STEP_16TH = 4'h8;

  localparam int VMIN_SHIFT = 5;

  // Maximum velocity in full steps per second.
  localparam logic [9:0] VMAX_LUT [16] = '{
    10'h063, 10'h088, 10'h0a7, 10'h0c5, 10'h0d5, 10'h0e4, 10'h0f3,
    10'h111, 10'h12f, 10'h14e, 10'h16c, 10'h18b, 10'h1c8, 10'h222,
    10'h2d9, 10'h3cd};

  // Acceleration in full steps per second squared.
  localparam logic [15:0] ACC_LUT [16] = '{
    16'h0031, 16'h00da, 16'h03ec, 16'h0e19, 16'h1854, 16'h2290,
    16'h2c91, 16'h3692, 16'h4093, 16'h4a94, 16'h557e, 16'h5f7f,
    16'h6980, 16'h7382, 16'h886d, 16'h9c6f};

  typedef enum logic [3:0] {
    CUR_RUN  = 4'b0001,
    CUR_HOLD = 4'b0010,
    CUR_DROP = 4'b0100,
    CUR_OFF  = 4'b1000
  } spd_cur_e;

endpackage : spd_pkg

// [logic/spd_param_decode.sv]
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
// How it works
// - At standstill the coil current falls from the run code to the hold code.
// - A hold code of all ones first drops to code zero, then stops the PWM and grounds the low-side switches.
// - The two-bit resolution field selects half, quarter, eighth or sixteenth stepping.
// - The shaft bit sets rotation sense and is ignored in continuous velocity mode.
// - Link loss or error-counter overflow sends the motor to the secure target.
// - A secure target whose upper nine bits read 100 0000 00 disables this, and the motor stays where it is.
// - The 11-bit secure target is the top of the 16-bit position, low bits zero.
// - The 9-bit nonvolatile copy loads into RAM with its two low bits zero.
// - Ramp rate, top speed and bottom speed come from their codes; bottom equals top times code over 32, code zero meaning equal.
// - With sleep permitted, a link timeout always requests sleep.
// - Without permission a timeout holds the motor stopped, except on a failure (no request) or from standby or shutdown (sleep requested).
// - A sleep command requests sleep when permitted and stop otherwise.
module spd_param_decode
  import spd_pkg::*;
(
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  // AXI4-Lite write
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  // AXI4-Lite read
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  // Motion and link events
  input  wire logic        MOTOR_MOVING,
  input  wire logic        LIN_LOST,
  input  wire logic        LIN_ERR_OVF,
  input  wire logic        LIN_TIMEOUT,
  input  wire logic        LIN_SLEEP_CMD,
  input  wire logic        IN_STANDBY,
  input  wire logic        IN_SHUTDOWN,
  input  wire logic        FAILURE,
  input  wire logic [15:0] ACT_POS,
  // Nonvolatile image
  input  wire logic [8:0]  OTP_SECURE,
  input  wire logic        OTP_LOAD,
  // Coil drive
  output logic [3:0]       COIL_CUR_CODE,
  output logic             PWM_EN,
  output logic             BOTTOM_GND,
  // Motion profile
  output logic [3:0]       STEP_RES,
  output logic             DIR_CW,
  output logic [9:0]       VMAX_FS,
  output logic [9:0]       VMIN_FS,
  output logic [15:0]      ACC_FS,
  output logic [15:0]      GOTO_POS,
  output logic             GOTO_EN,
  // Power state requests
  output logic             SLEEP_REQ,
  output logic             STOP_REQ
);
  import spd_pkg::*;

  spd_cfg_s    cfg_reg;
  logic [10:0] secure_target_reg;
  spd_cur_e    cur_reg;
  logic        aw_full_reg;
  logic        w_full_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_fire;
  logic        wr_hit;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        sec_off;
  logic        lose_evt;
  logic [13:0] vmin_prod;
  logic [9:0]  vmax_next;
  logic [9:0]  vmin_next;

  assign wr_fire   = aw_full_reg && w_full_reg && !BVALID;
  assign lose_evt  = LIN_LOST || LIN_ERR_OVF;
  assign sec_off   = secure_target_reg[SEC_W-1:2] == SEC_DISABLE;
  assign vmax_next = VMAX_LUT[cfg_reg.vmax];
  assign vmin_prod = vmax_next * cfg_reg.vmin;
  // The product is 14 bits wide; the scaled result always fits 10 bits.
  assign vmin_next = (cfg_reg.vmin == 4'h0) ? vmax_next
                   : 10'(vmin_prod >> VMIN_SHIFT);

  // Address and data are caught separately so either may arrive first.
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end
    else if (AWVALID && AWREADY)
    begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= AWADDR;
    end
    else if (wr_fire)
      aw_full_reg <= 1'b0;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end
    else if (WVALID && WREADY)
    begin
      w_full_reg <= 1'b1;
      w_data_reg <= WDATA;
      w_strb_reg <= WSTRB;
    end
    else if (wr_fire)
      w_full_reg <= 1'b0;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
    end
    else
    begin
      AWREADY <= !aw_full_reg && !(AWVALID && AWREADY);
      WREADY  <= !w_full_reg && !(WVALID && WREADY);
    end
  end

  always_comb
  begin
    wr_hit = (aw_addr_reg == OFF_CFG) || (aw_addr_reg == OFF_SECURE)
          || (aw_addr_reg == OFF_OTPLD);
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      BVALID <= 1'b0;
      BRESP  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      BVALID <= 1'b1;
      BRESP  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (BREADY)
      BVALID <= 1'b0;
  end

  // Byte strobes are honoured per byte on the parameter word; the secure target takes a write only with both low strobes set.
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      cfg_reg <= CFG_RESET;
    else if (wr_fire && aw_addr_reg == OFF_CFG)
    begin
      for (int b = 0; b < 4; b++)
        if (w_strb_reg[b])
          for (int i = 0; i < 8; i++)
            if (b * 8 + i < CFG_W)
              cfg_reg[b*8+i] <= w_data_reg[b*8+i];
    end
  end

  // A nonvolatile reload beats a software write in the same cycle.
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      secure_target_reg <= SEC_RESET;
    else if (OTP_LOAD || (wr_fire && aw_addr_reg == OFF_OTPLD
                          && w_data_reg[0]))
      secure_target_reg <= {OTP_SECURE, 2'b00};
    else if (wr_fire && aw_addr_reg == OFF_SECURE && w_strb_reg[0]
             && w_strb_reg[1])
      secure_target_reg <= w_data_reg[SEC_W-1:0];
  end

  always_comb
  begin
    rd_hit  = 1'b1;
    rd_word = 32'h00000000;
    unique case (ARADDR)
      OFF_CFG:    rd_word = {7'h00, cfg_reg};
      OFF_SECURE: rd_word = {21'h000000, secure_target_reg};
      OFF_OTPLD:  rd_word = 32'h00000000;
      OFF_STATUS: rd_word = {16'h0000, 4'h0, cur_reg, COIL_CUR_CODE,
                             SLEEP_REQ, STOP_REQ, PWM_EN, BOTTOM_GND};
      OFF_VEL:    rd_word = {6'h00, VMIN_FS, 6'h00, VMAX_FS};
      OFF_ACC:    rd_word = {16'h0000, ACC_FS};
      OFF_GOTO:   rd_word = {15'h0000, GOTO_EN, GOTO_POS};
      default:    rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h00000000;
      RRESP   <= RESP_OKAY;
    end
    else if (ARVALID && ARREADY)
    begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b1;
      RDATA   <= rd_word;
      RRESP   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (RVALID)
    begin
      if (RREADY)
        RVALID <= 1'b0;
    end
    else
      ARREADY <= 1'b1;
  end

  // Current sequencer; the zero-current case passes through code zero
  // for one cycle so the regulator never switches off at run current.
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      cur_reg <= CUR_HOLD;
    else if (MOTOR_MOVING)
      cur_reg <= CUR_RUN;
    else
    begin
      unique case (cur_reg)
        CUR_RUN:  cur_reg <= (cfg_reg.ihold == CUR_ZERO_CODE) ? CUR_DROP
                                                              : CUR_HOLD;
        CUR_HOLD: cur_reg <= (cfg_reg.ihold == CUR_ZERO_CODE) ? CUR_DROP
                                                              : CUR_HOLD;
        CUR_DROP: cur_reg <= CUR_OFF;
        CUR_OFF:  cur_reg <= (cfg_reg.ihold == CUR_ZERO_CODE) ? CUR_OFF
                                                              : CUR_HOLD;
        default:  cur_reg <= CUR_HOLD;
      endcase
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      COIL_CUR_CODE <= CUR_LOW_CODE;
      PWM_EN        <= 1'b1;
      BOTTOM_GND    <= 1'b0;
    end
    else
    begin
      // code per state
      // A zero hold code never shows before the lowest code has been driven.
      COIL_CUR_CODE <= (cur_reg == CUR_RUN) ? cfg_reg.irun
                     : (cur_reg == CUR_HOLD
                        && cfg_reg.ihold != CUR_ZERO_CODE) ? cfg_reg.ihold
                     : CUR_LOW_CODE;
      PWM_EN        <= cur_reg != CUR_OFF;
      BOTTOM_GND    <= cur_reg == CUR_OFF;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      STEP_RES <= STEP_HALF;
      DIR_CW   <= 1'b0;
    end
    else
    begin
      unique case (cfg_reg.microstep_select)
        2'h0: STEP_RES <= STEP_HALF;
        2'h1: STEP_RES <= STEP_QRT;
        2'h2: STEP_RES <= STEP_8TH;
        2'h3: STEP_RES <= STEP_16TH;
      endcase
      if (!cfg_reg.cont_vel)
        DIR_CW <= cfg_reg.shaft;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      VMAX_FS <= 10'h000;
      VMIN_FS <= 10'h000;
      ACC_FS  <= 16'h0000;
    end
    else
    begin
      VMAX_FS <= vmax_next;
      VMIN_FS <= vmin_next;
      ACC_FS  <= ACC_LUT[cfg_reg.acc];
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      GOTO_EN  <= 1'b0;
      GOTO_POS <= 16'h0000;
    end
    else
    begin
      GOTO_EN <= lose_evt;
      if (lose_evt)
        GOTO_POS <= sec_off ? ACT_POS
                  : {secure_target_reg, {SEC_PAD{1'b0}}};
    end
  end

  // Requests are one-cycle pulses; the power manager latches them.
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      SLEEP_REQ <= 1'b0;
      STOP_REQ  <= 1'b0;
    end
    else
    begin
      SLEEP_REQ <= (LIN_TIMEOUT && (cfg_reg.sleep_permit || IN_STANDBY
                                    || IN_SHUTDOWN))
                || (LIN_SLEEP_CMD && cfg_reg.sleep_permit);
      STOP_REQ  <= (LIN_TIMEOUT && !cfg_reg.sleep_permit && !IN_STANDBY
                    && !IN_SHUTDOWN && !FAILURE)
                || (LIN_SLEEP_CMD && !cfg_reg.sleep_permit);
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  a_hold_after_run:
    assert property (cur_reg == CUR_RUN && !MOTOR_MOVING
                     && cfg_reg.ihold != CUR_ZERO_CODE
                     ##1 !MOTOR_MOVING |=> COIL_CUR_CODE == cfg_reg.ihold)
    else $error("hold code not applied at standstill");

  a_zero_sequence:
    assert property (cur_reg == CUR_DROP |=> COIL_CUR_CODE == CUR_LOW_CODE
                     && PWM_EN && !BOTTOM_GND ##1 ($past(MOTOR_MOVING, 2)
                     || (!PWM_EN && BOTTOM_GND)))
    else $error("zero current sequence out of order");

  a_step_decode:
    assert property (##1 STEP_RES == (4'h1 << $past(cfg_reg.microstep_select)))
    else $error("step resolution mismatch");

  a_shaft_frozen:
    assert property (cfg_reg.cont_vel |=> $stable(DIR_CW))
    else $error("direction moved in velocity mode");

  a_secure_goto:
    assert property (lose_evt && !sec_off |=> GOTO_EN
                     && GOTO_POS == {$past(secure_target_reg), 5'h00})
    else $error("secure target not issued");

  a_secure_off:
    assert property (lose_evt && sec_off |=> GOTO_POS == $past(ACT_POS))
    else $error("disabled secure target moved motor");

  a_otp_pad:
    assert property (OTP_LOAD |=> secure_target_reg
                     == {$past(OTP_SECURE), 2'b00})
    else $error("nonvolatile load low bits not zero");

  a_vmin_equal:
    assert property ((cfg_reg.vmin == 4'h0) [*2] |-> VMIN_FS == VMAX_FS)
    else $error("minimum velocity code zero not equal to max");

  a_sleep_timeout:
    assert property (LIN_TIMEOUT && cfg_reg.sleep_permit |=> SLEEP_REQ)
    else $error("timeout with permission did not sleep");

  a_no_auto_sleep:
    assert property (LIN_TIMEOUT && !LIN_SLEEP_CMD && !cfg_reg.sleep_permit
                     && !IN_STANDBY && !IN_SHUTDOWN |=> !SLEEP_REQ)
    else $error("timeout slept without permission");

  a_sleep_command:
    assert property (LIN_SLEEP_CMD && !cfg_reg.sleep_permit |=> STOP_REQ)
    else $error("sleep command without permission did not stop");

  c_zero_off: cover property (cur_reg == CUR_DROP ##1 cur_reg == CUR_OFF);
  c_secure:   cover property (lose_evt && !sec_off);
  c_sleep:    cover property (LIN_SLEEP_CMD && cfg_reg.sleep_permit);
  c_wr_rd:    cover property (wr_fire ##[1:4] (ARVALID && ARREADY));

endmodule : spd_param_decode

// [dv/spd_lin_master.sv]
`timescale 1ns/10ps
// Link master side: raises one-cycle link event pulses on request.
module spd_lin_master
(
  // Clock
  input  wire logic REF_CLK,
  // Link events
  output logic      LIN_LOST,
  output logic      LIN_ERR_OVF,
  output logic      LIN_TIMEOUT,
  output logic      LIN_SLEEP_CMD
);
  initial
  begin
    {LIN_LOST, LIN_ERR_OVF, LIN_TIMEOUT, LIN_SLEEP_CMD} = 4'h0;
  end
  // Kind 0 loss, 1 counter overflow, 2 timeout, 3 sleep command.
  // Each event lasts one cycle, since a master never repeats it.
  task automatic pulse(input int k);
    @(posedge REF_CLK);
    LIN_LOST    <= (k == 0);
    LIN_ERR_OVF <= (k == 1);
    LIN_TIMEOUT <= (k == 2);
    LIN_SLEEP_CMD <= (k == 3);
    @(posedge REF_CLK);
    {LIN_LOST, LIN_ERR_OVF, LIN_TIMEOUT, LIN_SLEEP_CMD} <= 4'h0;
  endtask : pulse
endmodule : spd_lin_master

// [dv/stepper_motion_param_decode_tb.sv]
`timescale 1ns/10ps
module stepper_motion_param_decode_tb;
  import spd_pkg::*;
  logic        ref_clk = 1'h0;
  logic        rst = 1'h1;
  logic [7:0]  awaddr = 8'h0;
  logic [7:0]  araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        moving = 1'h0, standby = 1'h0, otp_load = 1'h0;
  logic        shutdown = 1'h0, failure = 1'h0;
  logic        lost, ovf, tmo, slp;
  logic [15:0] act_pos = 16'h1234;
  logic [15:0] goto_pos, acc_fs;
  logic [8:0]  otp_sec = 9'h0;
  logic [3:0]  code, step_res;
  logic        pwm_en, bot_gnd, dir_cw, goto_en, sleep_req, stop_req;
  logic [9:0]  vmax_fs, vmin_fs;
  int          n_errors = 0;
  int          tests_run = 0;
  int          cyc = 0;

  always #25 ref_clk = ~ref_clk;

  spd_param_decode u_dut (
    .REF_CLK(ref_clk), .RST(rst),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .MOTOR_MOVING(moving), .LIN_LOST(lost), .LIN_ERR_OVF(ovf),
    .LIN_TIMEOUT(tmo), .LIN_SLEEP_CMD(slp), .IN_STANDBY(standby),
    .IN_SHUTDOWN(shutdown), .FAILURE(failure), .ACT_POS(act_pos),
    .OTP_SECURE(otp_sec), .OTP_LOAD(otp_load),
    .COIL_CUR_CODE(code), .PWM_EN(pwm_en), .BOTTOM_GND(bot_gnd),
    .STEP_RES(step_res), .DIR_CW(dir_cw), .VMAX_FS(vmax_fs),
    .VMIN_FS(vmin_fs), .ACC_FS(acc_fs), .GOTO_POS(goto_pos),
    .GOTO_EN(goto_en), .SLEEP_REQ(sleep_req), .STOP_REQ(stop_req));

  spd_lin_master u_lin (
    .REF_CLK(ref_clk), .LIN_LOST(lost), .LIN_ERR_OVF(ovf),
    .LIN_TIMEOUT(tmo), .LIN_SLEEP_CMD(slp));

  task automatic complete_run;
    $display("tests_run %0d n_errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // A stuck handshake would otherwise hang the run forever.
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      complete_run;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do
    begin
      @(posedge ref_clk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk(bresp, er);
    repeat (2) @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do
    begin
      @(posedge ref_clk);
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    chk(rdata, e);
    chk(rresp, er);
  endtask : rd

  task automatic t_reset;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(vmax_fs, 32'h63);
    chk(acc_fs, 32'h31);
    chk({pwm_en, bot_gnd}, 32'h2);
  endtask : t_reset

  task automatic t_bus;
    wr(8'h40, 32'h1, RESP_SLVERR);
    rd(8'h40, 32'h0, RESP_SLVERR);
  endtask : t_bus

  task automatic t_step;
    for (int i = 0; i < 4; i++)
    begin
      wr(OFF_CFG, i << 21, RESP_OKAY);
      chk(step_res, 1 << i);
    end
  endtask : t_step

  task automatic t_vel;
    int vm [3] = '{973, 273, 99};
    int am [3] = '{40047, 1004, 49};
    int cv [3] = '{15, 7, 0};
    int ci [3] = '{1, 0, 15};
    int ca [3] = '{15, 2, 0};
    for (int i = 0; i < 3; i++)
    begin
      wr(OFF_CFG, (cv[i] << 8) | (ci[i] << 12) | (ca[i] << 16),
         RESP_OKAY);
      chk(vmax_fs, vm[i]);
      chk(vmin_fs, ci[i] == 0 ? vm[i] : vm[i] * ci[i] / 32);
      chk(acc_fs, am[i]);
    end
  endtask : t_vel

  task automatic t_dir;
    wr(OFF_CFG, 32'h100000, RESP_OKAY);
    chk(dir_cw, 32'h1);
    wr(OFF_CFG, 32'h1000000, RESP_OKAY);
    chk(dir_cw, 32'h1);
  endtask : t_dir

  task automatic t_cur;
    wr(OFF_CFG, 32'h35, RESP_OKAY);
    moving <= 1'h1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(code, 32'h5);
    @(posedge ref_clk);
    moving <= 1'h0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(code, 32'h3);
    wr(OFF_CFG, 32'hf5, RESP_OKAY);
    @(posedge ref_clk);
    moving <= 1'h1;
    repeat (3) @(posedge ref_clk);
    moving <= 1'h0;
    for (int i = 0; i < 6 && code !== 4'h0; i++)
    begin
      @(posedge ref_clk);
      #1;
    end
    // The regulator must still run when the lowest code first shows.
    chk({code, pwm_en, bot_gnd}, 32'h2);
    repeat (2) @(posedge ref_clk);
    #1;
    chk({code, pwm_en, bot_gnd}, 32'h1);
  endtask : t_cur

  task automatic t_sec;
    logic [10:0] s [3] = '{11'h123, 11'h401, 11'h404};
    for (int i = 0; i < 3; i++)
    begin
      wr(OFF_SECURE, s[i], RESP_OKAY);
      u_lin.pulse(i == 1);
      #1;
      chk(goto_en, 32'h1);
      chk(goto_pos, i == 1 ? act_pos : {s[i], 5'h0});
      @(posedge ref_clk);
      #1;
      chk(goto_en, 32'h0);
    end
  endtask : t_sec

  task automatic t_otp;
    @(posedge ref_clk);
    otp_sec  <= 9'h1ab;
    otp_load <= 1'h1;
    @(posedge ref_clk);
    otp_load <= 1'h0;
    rd(OFF_SECURE, 32'h6ac, RESP_OKAY);
    otp_sec <= 9'h0ff;
    wr(OFF_OTPLD, 32'h1, RESP_OKAY);
    rd(OFF_SECURE, 32'h3fc, RESP_OKAY);
  endtask : t_otp

  task automatic t_sleep;
    logic [6:0] tb [7] = '{7'h0a, 7'h01, 7'h06, 7'h22, 7'h40, 7'h1a, 7'h11};
    for (int i = 0; i < 7; i++)
    begin
      wr(OFF_CFG, 32'(tb[i][3]) << 23, RESP_OKAY);
      standby  <= tb[i][2];
      shutdown <= tb[i][5];
      failure  <= tb[i][6];
      u_lin.pulse(tb[i][4] ? 3 : 2);
      #1;
      chk({sleep_req, stop_req}, tb[i][1:0]);
      standby  <= 1'h0;
      shutdown <= 1'h0;
      failure  <= 1'h0;
    end
  endtask : t_sleep

  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
    t_reset;
    t_bus;
    t_step;
    t_vel;
    t_dir;
    t_cur;
    t_sec;
    t_otp;
    t_sleep;
    complete_run;
  end
endmodule : stepper_motion_param_decode_tb
